// *** src/core_pkg.sv ***
// constants and types of the alu and program memory core slice
// assumes a single sys_clk domain and four phases per instruction cycle
package core_pkg;

  // -------------------------------------------------------------------
  // sizes and fixed addresses
  // -------------------------------------------------------------------
  localparam int PROG_DEPTH = 512;
  localparam int ADDR_W = 9;
  localparam int WORD_W = 12;
  localparam int DATA_W = 8;
  localparam logic [8:0] RESET_VECTOR = 9'h000;
  localparam logic [8:0] LAST_PAGE_BASE = 9'h100;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_READ = 2'h1;
  localparam logic [1:0] PHASE_PRE_LAST = 2'h2;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [3:0] NIBBLE_MAX = 4'h9;
  localparam logic [3:0] BCD_ADJUST = 4'h6;
  localparam logic [3:0] IMM_HIGH = 4'h0;
  localparam logic [4:0] SER_ADDR_BITS = 5'h09;
  localparam logic [4:0] SER_WORD_BITS = 5'h0c;

  // -------------------------------------------------------------------
  // operations
  // -------------------------------------------------------------------
  typedef enum logic [4:0] {
    op_nop, op_add, op_adc, op_sub, op_sbc, op_daa,
    op_and, op_or, op_xor, op_cpl,
    op_rr, op_rrc, op_rl, op_rlc, op_inc, op_dec,
    op_mov_imm, op_swap, op_ret_imm,
    op_jmp, op_call, op_ret, op_reti,
    op_sz, op_snz, op_siz, op_sdz,
    op_table_read_present_page, op_table_read_last_page, op_pcl_write
  } alu_op_type;

  typedef struct packed {
    alu_op_type op;
    logic to_mem;
    logic use_imm;
    logic [7:0] mem_data;
    logic [7:0] imm;
    logic [8:0] target;
  } alu_cmd_type;

  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } status_type;

  typedef struct packed {
    logic [7:0] res;
    status_type flags;
    status_type upd;
    logic skip;
    logic branch;
    logic writes;
  } alu_res_type;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mem_wr_type;

endpackage

// *** src/alu_and_program_memory_core.sv ***
// alu, program memory, table read and serial program/debug access
// assumes cmd comes from same-clock decode logic; pins are asynchronous
// Contract
// [RULE1] result to named register, status updated
// [RULE2] add, adc, sub, sbc, decimal adjust
// [RULE3] and, or, xor, complement to acc or memory
// [RULE4] rotate left/right, with or without carry
// [RULE5] increment or decrement memory operand
// [RULE6] branch, call, return and skip decisions
// [RULE7] immediate takes low nibble, high must be zero
// [RULE8] eight-bit constant via load, swap, load
// [RULE9] program memory 512 words of 12 bits
// [RULE10] reset fetch starts at address 000h
// [RULE11] table pointer selects program word
// [RULE12] table read returns low eight bits only
// [RULE13] present-page read offsets from current page
// [RULE14] last-page read offsets from 100h
// [RULE15] table instructions take two instruction cycles
// [RULE16] software avoids table reads in both contexts
// [RULE17] serial data and clock transfer both directions; here only data is two-way, the clock pin stays input only
// [RULE18] nothing else drives the shared programming pins
// [RULE19] debug data two-way, debug clock input only
// [RULE20] shared pin functions dead while debugging
// [RULE21] only low eight pc bits reachable
// [RULE22] fetch held during table second cycle
// [RULE23] decimal adjust adds six per nibble
module alu_and_program_memory_core #(
  parameter int DEPTH = core_pkg::PROG_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input core_pkg::alu_cmd_type cmd,
  input wire logic [7:0] table_ptr,
  output logic cmd_ready,
  output logic [7:0] acc,
  output core_pkg::status_type status,
  output core_pkg::mem_wr_type mem_wr,
  output logic skip,
  output logic branch_taken,
  output logic imm_fault,
  output logic [11:0] instr,
  output logic [7:0] pc_low_byte,
  input wire logic prog_mode,
  input wire logic debug_mode,
  input wire logic port_a_bit_zero_in,
  output logic port_a_bit_zero_out,
  output logic port_a_bit_zero_oe,
  input wire logic port_a_bit_two_in,
  output logic port_a_bit_two_out,
  output logic port_a_bit_two_oe,
  input wire logic [1:0] gpio_out,
  input wire logic [1:0] gpio_oe,
  output logic [1:0] gpio_in
);

  // -------------------------------------------------------------------
  // alu evaluation
  // -------------------------------------------------------------------
  function automatic core_pkg::alu_res_type alu_eval(
    input core_pkg::alu_op_type op, input logic [7:0] a,
    input logic [7:0] b, input core_pkg::status_type st);
    core_pkg::alu_res_type r;
    logic [8:0] sum, adj;
    logic [4:0] lo;
    logic [7:0] bx;
    logic ci;
    r = '0;
    r.flags = st;
    bx = (op == core_pkg::op_sub || op == core_pkg::op_sbc) ? ~b : b;
    ci = (op == core_pkg::op_sub) ? 1'b1 :
         (op == core_pkg::op_add) ? 1'b0 : st.c;
    sum = {1'b0, a} + {1'b0, bx} + {8'h00, ci}; // RULE2
    lo = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    adj = {1'b0, a};
    if (a[3:0] > core_pkg::NIBBLE_MAX || st.ac)
      adj = adj + {5'h00, core_pkg::BCD_ADJUST}; // RULE23
    if (adj[7:4] > core_pkg::NIBBLE_MAX || st.c || adj[8])
      adj = adj + {1'b0, core_pkg::BCD_ADJUST, 4'h0}; // RULE23
    case (op)
      core_pkg::op_add, core_pkg::op_adc,
      core_pkg::op_sub, core_pkg::op_sbc: begin
        r.res = sum[7:0];
        r.flags.c = sum[8];
        r.flags.ac = lo[4];
        r.flags.ov = (a[7] == bx[7]) && (sum[7] != a[7]);
        r.upd = '1;
      end
      core_pkg::op_daa: begin
        r.res = adj[7:0];
        r.flags.c = adj[8] | st.c;
        r.upd.c = 1'b1;
      end
      core_pkg::op_and: r.res = a & b; // RULE3
      core_pkg::op_or: r.res = a | b; // RULE3
      core_pkg::op_xor: r.res = a ^ b; // RULE3
      core_pkg::op_cpl: r.res = ~b; // RULE3
      core_pkg::op_rr: r.res = {b[0], b[7:1]}; // RULE4
      core_pkg::op_rl: r.res = {b[6:0], b[7]}; // RULE4
      core_pkg::op_rrc: r.res = {st.c, b[7:1]}; // RULE4
      core_pkg::op_rlc: r.res = {b[6:0], st.c}; // RULE4
      core_pkg::op_inc, core_pkg::op_siz: r.res = b + 8'h01; // RULE5
      core_pkg::op_dec, core_pkg::op_sdz: r.res = b - 8'h01; // RULE5
      core_pkg::op_mov_imm, core_pkg::op_ret_imm:
        r.res = {a[7:4], b[3:0]}; // RULE8
      core_pkg::op_swap: r.res = {a[3:0], a[7:4]}; // RULE8
      default: r.res = b;
    endcase
    if (op == core_pkg::op_rrc || op == core_pkg::op_rlc) begin
      r.flags.c = (op == core_pkg::op_rrc) ? b[0] : b[7]; // RULE4
      r.upd.c = 1'b1;
    end
    if (op inside {core_pkg::op_and, core_pkg::op_or, core_pkg::op_xor,
                   core_pkg::op_cpl, core_pkg::op_inc, core_pkg::op_dec})
      r.upd.z = 1'b1;
    r.flags.z = r.upd.z ? (r.res == 8'h00) : st.z;
    r.writes = !(op inside {core_pkg::op_nop, core_pkg::op_jmp,
      core_pkg::op_call, core_pkg::op_ret, core_pkg::op_reti,
      core_pkg::op_sz, core_pkg::op_snz, core_pkg::op_pcl_write,
      core_pkg::op_table_read_present_page,
      core_pkg::op_table_read_last_page});
    r.branch = op inside {core_pkg::op_jmp, core_pkg::op_call,
      core_pkg::op_ret, core_pkg::op_reti, core_pkg::op_ret_imm}; // RULE6
    r.skip = ((op == core_pkg::op_sz || op == core_pkg::op_siz ||
               op == core_pkg::op_sdz) && r.res == 8'h00) ||
             (op == core_pkg::op_snz && b != 8'h00); // RULE6
    return r;
  endfunction

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {ser_cmd, ser_addr, ser_wdata,
    ser_rdata} ser_state_type;

  logic [11:0] mem [0:DEPTH-1]; // RULE9
  logic [11:0] rd_word, ser_shift;
  logic [8:0] pc, instr_addr, tbl_addr, ser_addr_reg;
  logic [2:0] clk_sync;
  logic [1:0] phase, dat_sync, mode_sync, dbg_sync;
  logic tbl_pending, ser_write, ser_oe, ser_bit;
  ser_state_type ser_state;
  logic [4:0] ser_cnt;

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  wire ser_active = mode_sync[1] | dbg_sync[1];
  wire ser_rise = clk_sync[1] & ~clk_sync[2];
  wire ser_fall = ~clk_sync[1] & clk_sync[2];
  wire take = cmd_valid & cmd_ready & (phase == core_pkg::PHASE_LAST);
  wire uses_imm = cmd.use_imm | (cmd.op == core_pkg::op_mov_imm) |
                  (cmd.op == core_pkg::op_ret_imm);
  wire imm_bad = uses_imm & (cmd.imm[7:4] != core_pkg::IMM_HIGH);
  wire [7:0] imm_val = {core_pkg::IMM_HIGH, cmd.imm[3:0]}; // RULE7
  wire [7:0] operand_b = uses_imm ? imm_val : cmd.mem_data;
  core_pkg::alu_res_type alu_out;
  assign alu_out = alu_eval(cmd.op, acc, operand_b, status);
  wire is_table = (cmd.op == core_pkg::op_table_read_present_page) ||
                  (cmd.op == core_pkg::op_table_read_last_page);
  wire [8:0] next_tbl_addr =
    (cmd.op == core_pkg::op_table_read_last_page) ?
    (core_pkg::LAST_PAGE_BASE | {1'b0, table_ptr}) : // RULE14
    {instr_addr[8], table_ptr}; // RULE13 RULE11
  wire to_mem_dest = cmd.to_mem & (cmd.op != core_pkg::op_mov_imm) &
                     (cmd.op != core_pkg::op_swap) &
                     (cmd.op != core_pkg::op_ret_imm);
  wire [8:0] rd_addr = ser_active ? ser_addr_reg :
                       tbl_pending ? tbl_addr : pc; // RULE22
  wire ser_word_done = (ser_cnt == core_pkg::SER_WORD_BITS - 5'h01);
  wire [3:0] rd_bit_idx = 4'(core_pkg::SER_WORD_BITS - 5'h01 - ser_cnt);

  // -------------------------------------------------------------------
  // program memory and phase divider
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (ser_active && ser_state == ser_wdata && ser_rise && ser_word_done)
      mem[ser_addr_reg] <= {ser_shift[10:0], dat_sync[1]}; // RULE17
    rd_word <= mem[rd_addr];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase <= core_pkg::PHASE_FIRST;
      cmd_ready <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      cmd_ready <= (phase == core_pkg::PHASE_PRE_LAST) && !tbl_pending &&
                   !ser_active; // RULE15
    end
  end

  // -------------------------------------------------------------------
  // fetch, program counter and table access
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc <= core_pkg::RESET_VECTOR; // RULE10
      instr_addr <= core_pkg::RESET_VECTOR;
      instr <= 12'h000;
      tbl_pending <= 1'b0;
      tbl_addr <= core_pkg::RESET_VECTOR;
    end else if (!ser_active) begin
      if (phase == core_pkg::PHASE_READ && !tbl_pending) begin
        instr <= rd_word;
        instr_addr <= pc;
      end
      if (phase == core_pkg::PHASE_LAST) begin
        if (take && alu_out.branch)
          pc <= cmd.target; // RULE6
        else if (take && cmd.op == core_pkg::op_pcl_write)
          pc <= {pc[8], cmd.mem_data}; // RULE21
        else if (!tbl_pending)
          pc <= pc + 9'h001; // RULE22
        tbl_pending <= take & is_table; // RULE15
        if (take && is_table)
          tbl_addr <= next_tbl_addr;
      end
    end
  end

  assign pc_low_byte = pc[7:0]; // RULE21

  // -------------------------------------------------------------------
  // execute and write back
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {acc, status, mem_wr, skip, branch_taken, imm_fault} <= '0;
    end else begin
      mem_wr.valid <= 1'b0;
      imm_fault <= take & imm_bad; // RULE7
      skip <= take & alu_out.skip; // RULE6
      branch_taken <= take & alu_out.branch; // RULE6
      if (tbl_pending && phase == core_pkg::PHASE_LAST && !ser_active) begin
        mem_wr.valid <= 1'b1;
        mem_wr.data <= rd_word[7:0]; // RULE12
      end
      if (take) begin
        status <= alu_out.flags; // RULE1
        if (alu_out.writes && to_mem_dest) begin
          mem_wr.valid <= 1'b1; // RULE1
          mem_wr.data <= alu_out.res;
        end else if (alu_out.writes)
          acc <= alu_out.res; // RULE1
      end
    end
  end

  // -------------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {clk_sync, dat_sync, mode_sync, dbg_sync} <= '0;
    end else begin
      clk_sync <= {clk_sync[1:0], port_a_bit_two_in}; // RULE19
      dat_sync <= {dat_sync[0], port_a_bit_zero_in};
      mode_sync <= {mode_sync[0], prog_mode};
      dbg_sync <= {dbg_sync[0], debug_mode};
    end
  end

  // -------------------------------------------------------------------
  // serial access: 1 direction bit, 9 address bits, 12 data bits
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ser_state <= ser_cmd;
      {ser_cnt, ser_write, ser_addr_reg, ser_shift, ser_oe, ser_bit} <= '0;
    end else if (!ser_active) begin
      ser_state <= ser_cmd;
      ser_cnt <= 5'h00;
      ser_oe <= 1'b0;
    end else begin
      case (ser_state)
        ser_cmd: if (ser_rise) begin
          ser_write <= dat_sync[1];
          ser_cnt <= 5'h00;
          ser_state <= ser_addr;
        end
        ser_addr: if (ser_rise) begin
          ser_addr_reg <= {ser_addr_reg[7:0], dat_sync[1]};
          ser_cnt <= ser_cnt + 5'h01;
          if (ser_cnt == core_pkg::SER_ADDR_BITS - 5'h01) begin
            ser_cnt <= 5'h00;
            ser_state <= ser_write ? ser_wdata : ser_rdata;
          end
        end
        ser_wdata: if (ser_rise) begin
          ser_shift <= {ser_shift[10:0], dat_sync[1]}; // RULE17
          ser_cnt <= ser_cnt + 5'h01;
          if (ser_word_done)
            ser_state <= ser_cmd;
        end
        default: begin
          if (ser_fall) begin
            ser_oe <= 1'b1; // RULE17 RULE19
            ser_bit <= rd_word[rd_bit_idx];
          end
          if (ser_rise && ser_oe) begin
            ser_cnt <= ser_cnt + 5'h01;
            if (ser_word_done) begin
              ser_oe <= 1'b0;
              ser_state <= ser_cmd;
            end
          end
        end
      endcase
    end
  end

  // -------------------------------------------------------------------
  // shared pin muxing
  // -------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {port_a_bit_zero_out, port_a_bit_zero_oe, port_a_bit_two_out,
       port_a_bit_two_oe, gpio_in} <= '0;
    end else if (ser_active) begin
      port_a_bit_zero_out <= ser_bit;
      port_a_bit_zero_oe <= ser_oe; // RULE18 RULE19
      port_a_bit_two_out <= 1'b0;
      port_a_bit_two_oe <= 1'b0; // RULE19
      gpio_in <= 2'h0; // RULE20
    end else begin
      port_a_bit_zero_out <= gpio_out[0];
      port_a_bit_zero_oe <= gpio_oe[0];
      port_a_bit_two_out <= gpio_out[1];
      port_a_bit_two_oe <= gpio_oe[1];
      gpio_in <= {clk_sync[1], dat_sync[1]};
    end
  end

endmodule

// *** sim/core_assertions.sv ***
// port checker of the alu and program memory core slice
// assumes the bind below and a single sys_clk domain
module core_assertions (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input core_pkg::alu_cmd_type cmd,
  input wire logic cmd_ready,
  input core_pkg::mem_wr_type mem_wr,
  input wire logic skip,
  input wire logic branch_taken,
  input wire logic imm_fault,
  input wire logic [7:0] pc_low_byte,
  input wire logic prog_mode,
  input wire logic debug_mode,
  input wire logic port_a_bit_two_oe,
  input wire logic [1:0] gpio_in
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic take, tbl, ser, imm_op, br_op, wr_op, md_zero;
  logic [3:0] imm_hi;
  assign take = cmd_valid && cmd_ready;
  assign tbl = take && (cmd.op == core_pkg::op_table_read_present_page
    || cmd.op == core_pkg::op_table_read_last_page);
  assign ser = prog_mode || debug_mode;
  assign imm_op = take && (cmd.op == core_pkg::op_mov_imm
    || cmd.op == core_pkg::op_ret_imm);
  assign br_op = take && (cmd.op == core_pkg::op_ret_imm
    || (cmd.op >= core_pkg::op_jmp && cmd.op <= core_pkg::op_reti));
  assign wr_op = take && cmd.to_mem && cmd.op != core_pkg::op_daa
    && cmd.op >= core_pkg::op_add && cmd.op <= core_pkg::op_dec;
  assign md_zero = cmd.mem_data == 8'h00;
  assign imm_hi = cmd.imm[7:4];
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_table_gap: assert property (
    tbl && !ser |=> !cmd_ready [*7] ##1 cmd_ready)
    else $error("table read spacing wrong");
  chk_table_data: assert property (
    tbl |-> ##[4:5] mem_wr.valid) else $error("table data missing");
  chk_imm_fault: assert property (
    imm_op |=> imm_fault == ($past(imm_hi) != 4'h0))
    else $error("immediate fault flag wrong");
  chk_branch_taken: assert property (
    br_op |=> branch_taken) else $error("branch not taken");
  chk_branch_cause: assert property (
    branch_taken |-> $past(take)) else $error("branch without take");
  chk_skip_zero: assert property (
    take && cmd.op == core_pkg::op_sz |=> skip == $past(md_zero))
    else $error("skip on zero wrong");
  chk_mem_write: assert property (
    wr_op |=> mem_wr.valid) else $error("memory result missing");
  chk_reset_pc: assert property (
    $fell(rst) |-> pc_low_byte == 8'h00 && !cmd_ready)
    else $error("reset start wrong");
  chk_serial_ready: assert property (
    ser [*5] |-> !cmd_ready) else $error("ready in serial mode");
  chk_clock_input: assert property (
    ser [*5] |-> !port_a_bit_two_oe && gpio_in == 2'h0)
    else $error("shared pin active in serial mode");
  cov_table: cover property (tbl);
  cov_fault: cover property (imm_op ##1 imm_fault);
  cov_skip: cover property (skip);
  cov_serial: cover property (ser [*5]);
endmodule

bind alu_and_program_memory_core core_assertions i_core_assertions (
  .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .mem_wr(mem_wr), .skip(skip),
  .branch_taken(branch_taken), .imm_fault(imm_fault),
  .pc_low_byte(pc_low_byte), .prog_mode(prog_mode),
  .debug_mode(debug_mode), .port_a_bit_two_oe(port_a_bit_two_oe),
  .gpio_in(gpio_in));

// *** sim/prog_tool_model.sv ***
// serial programming and debug tool on the two shared pins
// assumes the data wire is resolved here from both drivers
module prog_tool_model (
  input wire logic sys_clk,
  input wire logic dev_out,
  input wire logic dev_oe,
  output logic data_line,
  output logic clk_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_oe = 1'b0;
  logic host_val = 1'b0;
  logic last = 1'b0;
  initial clk_line = 1'b0;
  // undriven wire shows no stale level
  assign data_line = dev_oe ? dev_out : host_oe ? host_val : ~last;
  always @(posedge sys_clk) last <= data_line;
  task automatic gap(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic pulse();
    gap(4);
    clk_line = 1'b1;
    gap(4);
    clk_line = 1'b0;
  endtask
  task automatic head(input logic wr, input logic [8:0] a);
    host_oe = 1'b1;
    host_val = wr;
    pulse();
    for (int i = 8; i >= 0; i--) begin
      host_val = a[i];
      pulse();
    end
  endtask
  task automatic write_word(input logic [8:0] a, input logic [11:0] w);
    head(1'b1, a);
    for (int i = 11; i >= 0; i--) begin
      host_val = w[i];
      pulse();
    end
    host_oe = 1'b0;
    gap(8);
  endtask
  // device drives on the fall, tool samples at the rise
  task automatic read_word(input logic [8:0] a, output logic [11:0] w);
    head(1'b0, a);
    host_oe = 1'b0;
    for (int i = 11; i >= 0; i--) begin
      gap(6);
      w[i] = data_line;
      clk_line = 1'b1;
      gap(6);
      clk_line = 1'b0;
    end
    gap(8);
  endtask
endmodule

// *** sim/alu_and_program_memory_core_test.sv ***
// bench of the core slice: alu ops, table reads, serial access
// assumes core_pkg, the design, checker and tool model compiled first
module alu_and_program_memory_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rst = 1, cmd_valid = 0, prog_mode = 0;
  logic debug_mode = 0;
  logic [7:0] table_ptr = 8'h00;
  logic [1:0] gpio_out = 2'h0, gpio_oe = 2'h0, gpio_in;
  core_pkg::alu_cmd_type cmd = '0;
  logic cmd_ready, skip, branch_taken, imm_fault, d_out, d_oe;
  logic c_out, c_oe, d_line, c_line, pa2, m_c;
  logic [7:0] acc, pc_low_byte, m_acc, rnd = 8'h48;
  logic [11:0] instr, rw;
  logic [8:0] tgt = 9'h010;
  core_pkg::status_type status;
  core_pkg::mem_wr_type mem_wr;
  logic [7:0] exp_q[$];
  logic [11:0] words[4];
  logic [8:0] addrs[4] = '{9'h000, 9'h005, 9'h105, 9'h1ff};
  logic [7:0] bmd[8] = '{0, 0, 0, 0, 8'h00, 8'h00, 8'hff, 8'h01};
  int err_total = 0, n_checks = 0, n;
  assign pa2 = c_oe ? c_out : c_line;
  alu_and_program_memory_core i_alu_and_program_memory_core (
    .sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .table_ptr(table_ptr), .cmd_ready(cmd_ready), .acc(acc),
    .status(status), .mem_wr(mem_wr), .skip(skip),
    .branch_taken(branch_taken), .imm_fault(imm_fault), .instr(instr),
    .pc_low_byte(pc_low_byte), .prog_mode(prog_mode),
    .debug_mode(debug_mode), .port_a_bit_zero_in(d_line),
    .port_a_bit_zero_out(d_out), .port_a_bit_zero_oe(d_oe),
    .port_a_bit_two_in(pa2), .port_a_bit_two_out(c_out),
    .port_a_bit_two_oe(c_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_in(gpio_in));
  prog_tool_model i_prog_tool_model (.sys_clk(sys_clk), .dev_out(d_out),
    .dev_oe(d_oe), .data_line(d_line), .clk_line(c_line));
  always #2 sys_clk = ~sys_clk;
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // returns carry and result; b is the memory operand
  function automatic logic [8:0] model(input core_pkg::alu_op_type op,
      input logic [7:0] a, input logic [7:0] b, input logic c);
    case (op)
      core_pkg::op_add: return {1'b0, a} + {1'b0, b};
      core_pkg::op_adc: return {1'b0, a} + {1'b0, b} + 9'(c);
      core_pkg::op_sub: return {1'b0, a} + {1'b0, ~b} + 9'h001;
      core_pkg::op_sbc: return {1'b0, a} + {1'b0, ~b} + 9'(c);
      core_pkg::op_and: return {c, a & b};
      core_pkg::op_or: return {c, a | b};
      core_pkg::op_xor: return {c, a ^ b};
      core_pkg::op_cpl: return {c, ~b};
      core_pkg::op_rr: return {c, b[0], b[7:1]};
      core_pkg::op_rrc: return {b[0], c, b[7:1]};
      core_pkg::op_rl: return {c, b[6:0], b[7]};
      core_pkg::op_rlc: return {b[7], b[6:0], c};
      core_pkg::op_inc: return {c, b + 8'h01};
      default: return {c, b - 8'h01};
    endcase
  endfunction
  task automatic check(input string what, input logic [11:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic issue(input core_pkg::alu_op_type op, input logic tm,
      input logic [7:0] md, input logic [7:0] im);
    int k;
    k = 0;
    @(negedge sys_clk);
    cmd = '{op, tm, 1'b0, md, im, tgt};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && k < 40) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 40) check("ready", 12'h000, 12'h001);
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic load(input logic [7:0] v, input core_pkg::alu_op_type op);
    issue(core_pkg::op_mov_imm, 1'b0, 8'h00, {4'h0, v[7:4]});
    issue(core_pkg::op_swap, 1'b0, 8'h00, 8'h00);
    issue(op, 1'b0, 8'h00, {4'h0, v[3:0]});
    m_acc = v;
    check("constant", {4'h0, acc}, {4'h0, v});
  endtask
  task automatic alu_step(input int k, input logic tm);
    core_pkg::alu_op_type op;
    logic [8:0] r;
    op = core_pkg::alu_op_type'(k);
    rnd = lfsr(rnd);
    r = model(op, m_acc, rnd, m_c);
    if (tm) exp_q.push_back(r[7:0]);
    issue(op, tm, rnd, 8'h00);
    if (!tm) m_acc = r[7:0];
    m_c = r[8];
    check("acc", {4'h0, acc}, {4'h0, m_acc});
    check("carry", {11'h0, status.c}, {11'h0, m_c});
    if (k < 10 || k > 13)
      check("zero", {11'h0, status.z}, {11'h0, r[7:0] == 8'h0});
  endtask
  task automatic tbl(input core_pkg::alu_op_type op, input logic [7:0] p,
      input logic [7:0] e);
    table_ptr = p;
    exp_q.push_back(e);
    issue(op, 1'b1, 8'h00, 8'h00);
    repeat (5) @(negedge sys_clk);
  endtask
  // ---------------------------------------------------------------
  // result monitor and watchdog
  // ---------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (mem_wr.valid === 1'b1) begin
      if (exp_q.size() == 0) check("stray write", 12'h1, 12'h0);
      else check("mem", {4'h0, mem_wr.data}, {4'h0, exp_q.pop_front()});
    end
  end
  initial begin
    #100us;
    check("watchdog", 12'h1, 12'h0);
    results();
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    load(8'h3c, core_pkg::op_mov_imm);
    issue(core_pkg::op_daa, 1'b0, 8'h00, 8'h00);
    check("bcd", {4'h0, acc}, 12'h042);
    load(8'h9a, core_pkg::op_mov_imm);
    issue(core_pkg::op_daa, 1'b0, 8'h00, 8'h00);
    check("bcd", {3'h0, status.c, acc}, 12'h100);
    m_c = 1'b1;
    issue(core_pkg::op_mov_imm, 1'b0, 8'h00, 8'h15);
    check("imm fault", {11'h0, imm_fault}, 12'h001);
    issue(core_pkg::op_mov_imm, 1'b0, 8'h00, 8'h05);
    check("imm fault", {11'h0, imm_fault}, 12'h000);
    $display("test constants done");
    rnd = lfsr(rnd);
    load(rnd, core_pkg::op_mov_imm);
    for (int p = 0; p < 2; p++)
      for (int k = 1; k < 16; k++)
        if (k != 5) alu_step(k, p == 0);
    $display("test alu done");
    load(8'hc3, core_pkg::op_ret_imm);
    check("ret const", {11'h0, branch_taken}, 12'h001);
    for (int i = 0; i < 8; i++) begin
      issue(core_pkg::alu_op_type'(19 + i), 1'b0, bmd[i], 8'h00);
      check("branch", {11'h0, branch_taken}, {11'h0, i < 4});
      check("skip", {11'h0, skip}, {11'h0, 8'hd0 >> i & 8'h1});
    end
    $display("test branch done");
    prog_mode = 1'b1;
    repeat (8) @(negedge sys_clk);
    foreach (addrs[i]) begin
      rnd = lfsr(rnd);
      words[i] = {rnd[3:0], lfsr(rnd)};
      i_prog_tool_model.write_word(addrs[i], words[i]);
    end
    foreach (addrs[i]) begin
      i_prog_tool_model.read_word(addrs[i], rw);
      check("serial read", rw, words[i]);
    end
    prog_mode = 1'b0;
    $display("test serial done");
    tgt = 9'h010;
    issue(core_pkg::op_jmp, 1'b0, 8'h00, 8'h00);
    tbl(core_pkg::op_table_read_last_page, 8'h05, words[2][7:0]);
    tbl(core_pkg::op_table_read_last_page, 8'hff, words[3][7:0]);
    tbl(core_pkg::op_table_read_present_page, 8'h05, words[1][7:0]);
    tgt = 9'h180;
    issue(core_pkg::op_jmp, 1'b0, 8'h00, 8'h00);
    tbl(core_pkg::op_table_read_present_page, 8'h05, words[2][7:0]);
    check("pending", 12'(exp_q.size()), 12'h000);
    $display("test table done");
    rnd = lfsr(rnd);
    gpio_out = {1'b0, rnd[0]};
    gpio_oe = 2'h3;
    repeat (6) @(negedge sys_clk);
    check("pins", {10'h0, gpio_in}, {11'h0, rnd[0]});
    debug_mode = 1'b1;
    repeat (6) @(negedge sys_clk);
    check("pins", {10'h0, gpio_in}, 12'h000);
    i_prog_tool_model.read_word(addrs[1], rw);
    check("debug read", rw, words[1]);
    debug_mode = 1'b0;
    gpio_oe = 2'h0;
    $display("test debug done");
    rst = 1'b1;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    check("reset ready", {11'h0, cmd_ready}, 12'h001);
    check("reset fetch", instr, words[0]);
    $display("test reset done");
    results();
  end
endmodule
